// ### tfc_pkg.sv
// package for the thermal fan configuration bank
`default_nettype none
package tfc_pkg;
    localparam logic [7:0] TFC_ADDR_CFG = 8'h7d;
    localparam logic [7:0] TFC_ADDR_TEST_A = 8'h7e;
    localparam logic [7:0] TFC_ADDR_TEST_B = 8'h7f;
    localparam logic [7:0] TFC_ADDR_TEST_C = 8'h80;
    localparam logic [7:0] TFC_ADDR_LOCK = 8'hc0;
    localparam logic [7:0] TFC_ADDR_IRQ_STAT = 8'hc1;
    localparam logic [7:0] TFC_ADDR_IRQ_MASK = 8'hc2;
    localparam logic [7:0] TFC_RST_CFG = 8'h00;
    localparam logic [7:0] TFC_RST_TEST_A = 8'h00;
    localparam logic [7:0] TFC_RST_TEST_B = 8'h00;
    localparam logic [7:0] TFC_RST_TEST_C = 8'h10;
    localparam int TFC_BIT_ROLE_LO = 0;
    localparam int TFC_BIT_ROLE_HI = 1;
    localparam int TFC_BIT_OT_OFF = 2;
    localparam int TFC_BIT_FAN_TGT = 3;
    localparam int TFC_BIT_SCOPE = 4;
    localparam int TFC_BIT_BYPASS = 5;
    localparam int TFC_BIT_LOCK = 0;
    // interrupt status bits
    localparam int TFC_IRQ_LIMIT = 0;
    localparam int TFC_IRQ_LOCKED_WR = 1;
    localparam logic [7:0] TFC_FULL_DUTY = 8'hff;
    typedef enum logic [1:0] {
        TFC_ROLE_FAN_TACH = 2'b00,
        TFC_ROLE_THERMAL_LIMIT_PIN_PIN = 2'b01,
        TFC_ROLE_BUS_ALERT = 2'b10,
        TFC_ROLE_GPIO = 2'b11
    } tfc_role_e;
endpackage
`default_nettype wire

// ### tfc_sync.sv
// two flip-flop synchroniser, one per bit
`default_nettype none
module tfc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tfc_sync_s;
    tfc_sync_s st_ff;
    tfc_sync_s nxt_st;
    always_comb
    begin
        nxt_st.s1 = d_i;
        nxt_st.s2 = st_ff.s1;
    end
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
    assign q_o = st_ff.s2;
endmodule
`default_nettype wire

// ### tfc_bank.sv
// configuration register bank: pin role, over-temperature output, fan target
// How it works
// - role field routes shared pin: tach, thermal pin, bus alert, gpio
// - bit 2 set disables all over-temperature output on thermal pin
// - fan target clear: all fans full speed when limit exceeded
// - fan target set: each fan to its programmed maximum duty
// - variant bit 4: 0 remote 2 only, 1 remotes 1 and 2
// - bit 5 bypasses cpu-rail attenuator
// - lock bit set makes the configuration register ignore writes
// - configuration register resets to 0x00, pin as fan tach input
// - three factory test registers are read-only, all bits reserved
// - test registers reset to 0x00, 0x00 and 0x10
//
// The address-and-strobe port is this design's own decision.
`default_nettype none
module tfc_bank
    import tfc_pkg::*;
#(
    parameter bit HAS_SCOPE = 1'b1,
    parameter int NFAN = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // thermal limit events from the measurement side, per remote channel
    input wire logic limit_r1_i,
    input wire logic limit_r2_i,
    // programmed maximum duty per fan
    input wire logic [NFAN*8-1:0] fan_max_duty_i,
    input wire logic [NFAN*8-1:0] fan_loop_duty_i,
    output logic [NFAN*8-1:0] fan_duty_o,
    // shared pin, three signal form
    input wire logic shared_pin_i,
    input wire logic gpio_out_i,
    input wire logic bus_alert_i,
    output logic shared_pin_o,
    output logic shared_pin_oe_o,
    output logic fan_four_speed_input_o,
    output logic gpio_in_o,
    // thermal limit pin drive, open drain
    output logic thermal_limit_pin_o,
    output logic thermal_limit_pin_oe_o,
    // configuration for the measurement side
    output logic cpu_rail_attenuator_bypass_o,
    output logic remote_channel_scope_o,
    output logic [1:0] shared_pin_role_select_o,
    // interrupt
    output logic irq_o
);
    typedef struct packed {
        logic [7:0] cfg;
        logic lock;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic [7:0] rdata;
    } tfc_bank_s;

    tfc_bank_s st_ff;
    tfc_bank_s nxt_st;
    logic rst_b;
    logic pin_sync;
    logic limit_any;
    logic wr_cfg;
    logic [7:0] cfg_mask;

    // reset enters asynchronously but leaves on the clock
    tfc_sync #(
        .W(1)
    ) u_rst_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(1'b1),
        .q_o(rst_b)
    );

    // limit inputs are on the same clock; only the pin is synchronised
    tfc_sync #(
        .W(1)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .d_i(shared_pin_i),
        .q_o(pin_sync)
    );

    // writable bits; reserved ones never store
    assign cfg_mask = HAS_SCOPE ? 8'h3f : 8'h2f;
    assign limit_any = limit_r2_i
        | (st_ff.cfg[TFC_BIT_SCOPE] & limit_r1_i);
    assign wr_cfg = wr_i && addr_i == TFC_ADDR_CFG;

    always_comb
    begin
        nxt_st = st_ff;
        if (wr_cfg && !st_ff.lock)
            nxt_st.cfg = wdata_i & cfg_mask;
        if (wr_i && addr_i == TFC_ADDR_LOCK && wdata_i[TFC_BIT_LOCK])
            nxt_st.lock = 1'b1; // sticky until reset
        if (wr_i && addr_i == TFC_ADDR_IRQ_MASK)
            nxt_st.irq_mask = wdata_i;
        if (wr_i && addr_i == TFC_ADDR_IRQ_STAT)
            nxt_st.irq_stat = st_ff.irq_stat & ~wdata_i;
        // set wins over a clear in the same cycle
        if (limit_any)
            nxt_st.irq_stat[TFC_IRQ_LIMIT] = 1'b1;
        if (wr_cfg && st_ff.lock)
            nxt_st.irq_stat[TFC_IRQ_LOCKED_WR] = 1'b1;
        // test registers have no write path at all
        nxt_st.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                TFC_ADDR_CFG: nxt_st.rdata = st_ff.cfg;
                TFC_ADDR_TEST_A: nxt_st.rdata = TFC_RST_TEST_A;
                TFC_ADDR_TEST_B: nxt_st.rdata = TFC_RST_TEST_B;
                TFC_ADDR_TEST_C: nxt_st.rdata = TFC_RST_TEST_C;
                TFC_ADDR_LOCK: nxt_st.rdata = {7'h00, st_ff.lock};
                TFC_ADDR_IRQ_STAT: nxt_st.rdata = st_ff.irq_stat;
                TFC_ADDR_IRQ_MASK: nxt_st.rdata = st_ff.irq_mask;
                default: nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff.cfg <= TFC_RST_CFG;
            st_ff.lock <= 1'b0;
            st_ff.irq_stat <= 8'h00;
            st_ff.irq_mask <= 8'h00;
            st_ff.rdata <= 8'h00;
        end
        else
        begin
            st_ff.cfg <= nxt_st.cfg;
            st_ff.lock <= nxt_st.lock;
            st_ff.irq_stat <= nxt_st.irq_stat;
            st_ff.irq_mask <= nxt_st.irq_mask;
            st_ff.rdata <= nxt_st.rdata;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign irq_o = |(st_ff.irq_stat & st_ff.irq_mask);

    // fan override: full speed or programmed maximum during a limit
    genvar g;
    generate
        for (g = 0; g < NFAN; g++)
        begin : g_fan
            // one driver per slice keeps each fan independent
            assign fan_duty_o[g*8 +: 8] = !limit_any
                ? fan_loop_duty_i[g*8 +: 8]
                : (st_ff.cfg[TFC_BIT_FAN_TGT]
                ? fan_max_duty_i[g*8 +: 8]
                : TFC_FULL_DUTY);
        end
    endgenerate

    // shared pin routing
    always_comb
    begin
        shared_pin_o = 1'b0;
        shared_pin_oe_o = 1'b0;
        fan_four_speed_input_o = 1'b0;
        gpio_in_o = 1'b0;
        case (tfc_role_e'(st_ff.cfg[TFC_BIT_ROLE_HI:TFC_BIT_ROLE_LO]))
            TFC_ROLE_FAN_TACH: fan_four_speed_input_o = pin_sync;
            TFC_ROLE_THERMAL_LIMIT_PIN_PIN:
            begin
                shared_pin_o = 1'b0;
                shared_pin_oe_o = limit_any && !st_ff.cfg[TFC_BIT_OT_OFF];
            end
            TFC_ROLE_BUS_ALERT:
            begin
                shared_pin_o = 1'b0;
                shared_pin_oe_o = bus_alert_i;
            end
            TFC_ROLE_GPIO:
            begin
                shared_pin_o = gpio_out_i;
                shared_pin_oe_o = 1'b1;
                gpio_in_o = pin_sync;
            end
            default: shared_pin_o = 1'b0;
        endcase
    end

    // open drain: pulls low on a limit unless output is disabled
    assign thermal_limit_pin_o = 1'b0;
    assign thermal_limit_pin_oe_o = limit_any
        && !st_ff.cfg[TFC_BIT_OT_OFF];
    assign cpu_rail_attenuator_bypass_o = st_ff.cfg[TFC_BIT_BYPASS];
    assign remote_channel_scope_o = st_ff.cfg[TFC_BIT_SCOPE];
    assign shared_pin_role_select_o = st_ff.cfg[TFC_BIT_ROLE_HI:TFC_BIT_ROLE_LO];

    property p_lock_holds;
        @(posedge clk_i) disable iff (!rst_b)
        (st_ff.lock && wr_cfg) |=> $stable(st_ff.cfg);
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("locked configuration register changed");

    property p_write_stores;
        @(posedge clk_i) disable iff (!rst_b)
        (!st_ff.lock && wr_cfg) |=> st_ff.cfg == ($past(wdata_i) & cfg_mask);
    endproperty
    a_write_stores: assert property (p_write_stores)
        else $error("configuration write not stored");

    property p_full_speed;
        @(posedge clk_i) disable iff (!rst_b)
        (limit_any && !st_ff.cfg[TFC_BIT_FAN_TGT]) |->
            fan_duty_o[7:0] == TFC_FULL_DUTY;
    endproperty
    a_full_speed: assert property (p_full_speed)
        else $error("fan not at full speed on limit");

    property p_max_duty;
        @(posedge clk_i) disable iff (!rst_b)
        (limit_any && st_ff.cfg[TFC_BIT_FAN_TGT]) |->
            fan_duty_o[7:0] == fan_max_duty_i[7:0];
    endproperty
    a_max_duty: assert property (p_max_duty)
        else $error("fan not at programmed maximum on limit");

    property p_ot_off;
        @(posedge clk_i) disable iff (!rst_b)
        st_ff.cfg[TFC_BIT_OT_OFF] |-> !thermal_limit_pin_oe_o
            && !(shared_pin_role_select_o == TFC_ROLE_THERMAL_LIMIT_PIN_PIN
            && shared_pin_oe_o);
    endproperty
    a_ot_off: assert property (p_ot_off)
        else $error("thermal pin driven while disabled");

    property p_test_c;
        @(posedge clk_i) disable iff (!rst_b)
        (rd_i && addr_i == TFC_ADDR_TEST_C) |=> rdata_o == TFC_RST_TEST_C;
    endproperty
    a_test_c: assert property (p_test_c)
        else $error("test register three read wrong");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (!rst_b)
        st_ff.cfg[7:6] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved configuration bits set");

    property p_tach_route;
        @(posedge clk_i) disable iff (!rst_b)
        (st_ff.cfg[1:0] == 2'b00) |-> !shared_pin_oe_o;
    endproperty
    a_tach_route: assert property (p_tach_route)
        else $error("shared pin driven in tach role");

    property p_bypass;
        @(posedge clk_i) disable iff (!rst_b)
        (!st_ff.lock && wr_cfg && wdata_i[TFC_BIT_BYPASS]) |=>
            cpu_rail_attenuator_bypass_o;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass output mismatch");

    property p_lock_flag;
        @(posedge clk_i) disable iff (!rst_b)
        (st_ff.lock && wr_cfg) |=> st_ff.irq_stat[TFC_IRQ_LOCKED_WR];
    endproperty
    a_lock_flag: assert property (p_lock_flag)
        else $error("refused write not flagged");

    property p_thermal_limit_pin_drive;
        @(posedge clk_i) disable iff (!rst_b)
        (limit_any && !st_ff.cfg[TFC_BIT_OT_OFF]) |->
            thermal_limit_pin_oe_o && !thermal_limit_pin_o;
    endproperty
    a_thermal_limit_pin_drive: assert property (p_thermal_limit_pin_drive)
        else $error("thermal pin not pulled low on limit");

    property p_scope_only;
        @(posedge clk_i) disable iff (!rst_b)
        (!st_ff.cfg[TFC_BIT_SCOPE] && !limit_r2_i) |->
            fan_duty_o == fan_loop_duty_i;
    endproperty
    a_scope_only: assert property (p_scope_only)
        else $error("remote 1 limit acted outside its scope");

    property p_test_a;
        @(posedge clk_i) disable iff (!rst_b)
        (rd_i && addr_i == TFC_ADDR_TEST_A) |=> rdata_o == TFC_RST_TEST_A;
    endproperty
    a_test_a: assert property (p_test_a)
        else $error("test register one read wrong");

    property p_test_b;
        @(posedge clk_i) disable iff (!rst_b)
        (rd_i && addr_i == TFC_ADDR_TEST_B) |=> rdata_o == TFC_RST_TEST_B;
    endproperty
    a_test_b: assert property (p_test_b)
        else $error("test register two read wrong");

    property p_thermal_limit_pin_role;
        @(posedge clk_i) disable iff (!rst_b)
        (shared_pin_role_select_o == TFC_ROLE_THERMAL_LIMIT_PIN_PIN && limit_any
            && !st_ff.cfg[TFC_BIT_OT_OFF]) |->
            shared_pin_oe_o && !shared_pin_o;
    endproperty
    a_thermal_limit_pin_role: assert property (p_thermal_limit_pin_role)
        else $error("shared pin not pulled low in thermal role");

    property p_gpio_route;
        @(posedge clk_i) disable iff (!rst_b)
        (shared_pin_role_select_o == TFC_ROLE_GPIO) |->
            shared_pin_oe_o && shared_pin_o == gpio_out_i;
    endproperty
    a_gpio_route: assert property (p_gpio_route)
        else $error("shared pin not driven in gpio role");
endmodule
`default_nettype wire

// ### tfc_host.sv
// host model that drives the register port of the configuration bank
`default_nettype none
module tfc_host (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // factory test writes come only from refusal scenarios
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    // read data stand for one cycle only, so sample just past the edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ### test_thermal_fan_config_bank.sv
// self-checking bench for the thermal fan configuration bank
`default_nettype none
module test_thermal_fan_config_bank
    import tfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr, wdata, rdata, rv;
    logic wr, rd, lim1 = 1'b0, lim2 = 1'b0, pin = 1'b1, gout = 1'b1;
    logic alert = 1'b1;
    logic [31:0] maxd = 32'h55667788, loopd = 32'h11223344, duty;
    logic spo, spoe, tach, gin, tpo, tpoe, byp, scope, irq;
    logic [1:0] role;
    int fail_count = 0, n_tests = 0, cyc = 0;
    logic [15:0] rows [5] = '{16'h0000, 16'h2525, 16'h1a1a, 16'hff3f,
        16'hc303};
    logic [7:0] taddr [4] = '{8'h7d, 8'h7e, 8'h7f, 8'h80};
    logic [7:0] trst [4] = '{8'h00, 8'h00, 8'h00, 8'h10};
    always #2.5 clk = ~clk;
    tfc_host i_tfc_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    tfc_bank i_tfc_bank (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .limit_r1_i(lim1), .limit_r2_i(lim2), .fan_max_duty_i(maxd),
        .fan_loop_duty_i(loopd), .fan_duty_o(duty), .shared_pin_i(pin),
        .gpio_out_i(gout), .bus_alert_i(alert), .shared_pin_o(spo),
        .shared_pin_oe_o(spoe), .fan_four_speed_input_o(tach),
        .gpio_in_o(gin), .thermal_limit_pin_o(tpo),
        .thermal_limit_pin_oe_o(tpoe), .cpu_rail_attenuator_bypass_o(byp),
        .remote_channel_scope_o(scope), .shared_pin_role_select_o(role),
        .irq_o(irq));
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ceiling well above the roughly 180 cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk("role after reset", role, 2'b00);
        for (int p = 0; p < 2; p++)
        begin
            foreach (taddr[i])
            begin
                i_tfc_host.rd_reg(taddr[i], rv);
                chk("reset value", rv, trst[i]);
                if (i > 0)
                    i_tfc_host.wr_reg(taddr[i], 8'hff);
            end
        end
        $display("test reset and read-only done");
        foreach (rows[i])
        begin
            gout <= i[0];
            pin <= !i[0];
            alert <= !i[0];
            i_tfc_host.wr_reg(TFC_ADDR_CFG, rows[i][15:8]);
            i_tfc_host.rd_reg(TFC_ADDR_CFG, rv);
            chk("cfg readback", rv, rows[i][7:0]);
            settle();
            chk("role", role, rows[i][9:8]);
            chk("tach", tach, rows[i][9:8] == 2'b00 && !i[0]);
            chk("gpio in", gin, rows[i][9:8] == 2'b11 && !i[0]);
            chk("pin drive", spo, rows[i][9:8] == 2'b11 && i[0]);
            chk("pin enable", spoe, rows[i][9:8] == 2'b11
                || (rows[i][9:8] == 2'b10 && !i[0]));
            chk("bypass", byp, rows[i][13]);
            chk("scope", scope, rows[i][12]);
        end
        $display("test table done");
        i_tfc_host.wr_reg(TFC_ADDR_IRQ_MASK, 8'h00);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h00);
        lim2 <= 1'b1;
        settle();
        chk("full duty", duty, 32'hffffffff);
        chk("overtemp drive", tpoe, 1'b1);
        chk("overtemp level", tpo, 1'b0);
        chk("masked irq", irq, 1'b0);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h08);
        settle();
        chk("max duty", duty, maxd);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h0c);
        settle();
        chk("overtemp off", tpoe, 1'b0);
        lim2 <= 1'b0;
        lim1 <= 1'b1;
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h00);
        settle();
        chk("remote 2 only", duty, loopd);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h10);
        settle();
        chk("both remotes", duty, 32'hffffffff);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h11);
        settle();
        chk("thermal role drive", spoe, 1'b1);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h15);
        settle();
        chk("thermal role off", spoe, 1'b0);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h10);
        $display("test limit response done");
        i_tfc_host.wr_reg(TFC_ADDR_IRQ_MASK, 8'h01);
        settle();
        chk("irq raised", irq, 1'b1);
        // a clear that meets a live limit must lose
        i_tfc_host.wr_reg(TFC_ADDR_IRQ_STAT, 8'h01);
        settle();
        chk("set wins over clear", irq, 1'b1);
        lim1 <= 1'b0;
        i_tfc_host.wr_reg(TFC_ADDR_IRQ_STAT, 8'h01);
        settle();
        chk("irq cleared", irq, 1'b0);
        $display("test interrupt done");
        i_tfc_host.wr_reg(TFC_ADDR_LOCK, 8'h01);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h03);
        i_tfc_host.rd_reg(TFC_ADDR_CFG, rv);
        chk("locked cfg", rv, 8'h10);
        i_tfc_host.rd_reg(TFC_ADDR_IRQ_STAT, rv);
        chk("locked write status", rv, 8'h02);
        $display("test lock done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq in reset", irq, 1'b0);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        i_tfc_host.rd_reg(TFC_ADDR_CFG, rv);
        chk("cfg after reset", rv, TFC_RST_CFG);
        chk("role after mid-run reset", role, 2'b00);
        i_tfc_host.rd_reg(TFC_ADDR_LOCK, rv);
        chk("lock after reset", rv, 8'h00);
        i_tfc_host.wr_reg(TFC_ADDR_CFG, 8'h05);
        i_tfc_host.rd_reg(TFC_ADDR_CFG, rv);
        chk("unlocked by reset", rv, 8'h05);
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
